// ==== adc_output_port.sv ====
// output side of the dual-channel converter: latency, strobes, sync
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - sample appears exactly 40 encode edges later
// - words are 12-bit twos complement codes
// - outputs invalid until startup interval ends
// - reset idles high, sync idles low
// - sync accepted synchronous or asynchronous
// - strobes freeze while sync is asserted
// - sync samples dropped, valid 40 edges later
// - each data bit driven true and complement
// - each channel has differential ready strobe
// - bit 0 is the least significant bit
// - channel A mirrors channel B structure
module adc_output_port #(
	parameter int STARTUP_COUNT = adc_port_pkg::STARTUP_CYCLES
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// encode clock and capture sync pins
	input wire logic enc_clk_in,
	input wire logic sync_pin_in,
	// quantiser word, taken on the clk_in cycle of each encode edge
	input wire logic [adc_port_pkg::SAMPLE_W-1:0] sample_in,
	// channel A outputs
	output logic [adc_port_pkg::SAMPLE_W-1:0] chan_a_bits_true_out,
	output logic [adc_port_pkg::SAMPLE_W-1:0] chan_a_bits_comp_out,
	output logic ready_strobe_chan_a_true_out,
	output logic ready_strobe_chan_a_comp_out,
	// channel B outputs
	output logic [adc_port_pkg::SAMPLE_W-1:0] chan_b_bits_true_out,
	output logic [adc_port_pkg::SAMPLE_W-1:0] chan_b_bits_comp_out,
	output logic ready_strobe_chan_b_true_out,
	output logic ready_strobe_chan_b_comp_out
);
	import adc_port_pkg::*;

	localparam logic [STARTUP_W-1:0] STARTUP_LAST =
		STARTUP_W'(STARTUP_COUNT - 1);

	sample_pipe_if #(.W(SAMPLE_W)) pif ();

	// one stage per encode edge; the output load makes edge k+40
	sample_pipe #(.W(SAMPLE_W), .STAGES(LATENCY_CYCLES)) u_pipe (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.p(pif.pipe)
	);

	// encode clock: two flops, then an edge flop
	logic enc_s1_reg, enc_s2_reg, enc_s3_reg;
	logic enc_edge;
	// short async sync pulses flip a toggle on the pin edge itself
	logic catch_tog_reg, tog_s1_reg, tog_s2_reg, tog_s3_reg;
	logic sync_s1_reg, sync_s2_reg;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			enc_s1_reg <= 1'b0;
			enc_s2_reg <= 1'b0;
			enc_s3_reg <= 1'b0;
			sync_s1_reg <= 1'b0;
			sync_s2_reg <= 1'b0;
			tog_s1_reg <= 1'b0;
			tog_s2_reg <= 1'b0;
			tog_s3_reg <= 1'b0;
		end else begin
			enc_s1_reg <= enc_clk_in;
			enc_s2_reg <= enc_s1_reg;
			enc_s3_reg <= enc_s2_reg;
			// pad pull-down keeps an open pin low: idle means no sync
			sync_s1_reg <= sync_pin_in;
			tog_s1_reg <= catch_tog_reg;
			tog_s2_reg <= tog_s1_reg;
			tog_s3_reg <= tog_s2_reg;
			// a held level or one caught pulse halts the port
			sync_s2_reg <= sync_s1_reg || (tog_s2_reg != tog_s3_reg);
		end
	end

	assign enc_edge = enc_s2_reg && !enc_s3_reg;

	// a 5 ns pulse can fall between two 8 ns samples
	// no clear can swallow it, but two pulses between the same two clk_in edges cancel
	always_ff @(posedge sync_pin_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			catch_tog_reg <= 1'b0;
		end else begin
			catch_tog_reg <= !catch_tog_reg;
		end
	end

	// port state, startup count, channel phase, output words
	port_state_t state_reg, state_next;
	logic [STARTUP_W-1:0] start_cnt_reg, start_cnt_next;
	logic phase_reg, phase_next;
	logic [SAMPLE_W-1:0] word_a_reg, word_a_next;
	logic [SAMPLE_W-1:0] word_b_reg, word_b_next;
	logic strobe_a_reg, strobe_a_next;
	logic strobe_b_reg, strobe_b_next;
	logic load_a, load_b, running;

	assign running = state_reg == ST_RUN;
	assign load_a = running && enc_edge && pif.out_valid && !phase_reg;
	assign load_b = running && enc_edge && pif.out_valid && phase_reg;

	// discarded samples travel as invalid, so valid data resumes 40 later
	assign pif.shift = enc_edge;
	assign pif.in_valid = running && !sync_s2_reg;
	assign pif.in_word = sample_in;

	always_comb begin
		state_next = state_reg;
		start_cnt_next = start_cnt_reg;
		phase_next = phase_reg;
		word_a_next = word_a_reg;
		word_b_next = word_b_reg;
		strobe_a_next = strobe_a_reg;
		strobe_b_next = strobe_b_reg;
		case (state_reg)
			ST_STARTUP: begin
				// outputs stay quiet until the converter has settled
				if (start_cnt_reg == STARTUP_LAST) begin
					state_next = ST_RUN;
				end else begin
					start_cnt_next = start_cnt_reg + 1'b1;
				end
			end
			ST_RUN: begin
				if (sync_s2_reg) begin
					// restart on channel A so capture buffers line up
					state_next = ST_HALT;
					phase_next = 1'b0;
				end else if (load_a) begin
					word_a_next = pif.out_word;
					strobe_a_next = 1'b1;
					strobe_b_next = 1'b0;
					phase_next = 1'b1;
				end else if (load_b) begin
					word_b_next = pif.out_word;
					strobe_b_next = 1'b1;
					strobe_a_next = 1'b0;
					phase_next = 1'b0;
				end
			end
			ST_HALT: begin
				// strobes hold their level until sync is released
				if (!sync_s2_reg) begin
					state_next = ST_RUN;
				end
			end
			default: begin
				state_next = ST_STARTUP;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_reg <= ST_STARTUP;
			start_cnt_reg <= '0;
			phase_reg <= 1'b0;
			word_a_reg <= WORD_RESET;
			word_b_reg <= WORD_RESET;
			strobe_a_reg <= 1'b0;
			strobe_b_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			start_cnt_reg <= start_cnt_next;
			phase_reg <= phase_next;
			word_a_reg <= word_a_next;
			word_b_reg <= word_b_next;
			strobe_a_reg <= strobe_a_next;
			strobe_b_reg <= strobe_b_next;
		end
	end

	// differential pairs are both registered so they switch together
	logic [SAMPLE_W-1:0] comp_a_reg, comp_b_reg;
	logic sc_a_reg, sc_b_reg;
	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			comp_a_reg <= ~WORD_RESET;
			comp_b_reg <= ~WORD_RESET;
			sc_a_reg <= 1'b1;
			sc_b_reg <= 1'b1;
		end else begin
			comp_a_reg <= ~word_a_next;
			comp_b_reg <= ~word_b_next;
			sc_a_reg <= ~strobe_a_next;
			sc_b_reg <= ~strobe_b_next;
		end
	end

	assign chan_a_bits_true_out = word_a_reg;
	assign chan_a_bits_comp_out = comp_a_reg;
	assign chan_b_bits_true_out = word_b_reg;
	assign chan_b_bits_comp_out = comp_b_reg;
	assign ready_strobe_chan_a_true_out = strobe_a_reg;
	assign ready_strobe_chan_a_comp_out = sc_a_reg;
	assign ready_strobe_chan_b_true_out = strobe_b_reg;
	assign ready_strobe_chan_b_comp_out = sc_b_reg;

	sequence s_load_a;
		load_a;
	endsequence
	sequence s_word_a_shown;
		##1 ready_strobe_chan_a_true_out && !ready_strobe_chan_b_true_out;
	endsequence

	property p_load_word;
		@(posedge clk_in) disable iff (!rst_n_in)
		load_a |=> chan_a_bits_true_out == $past(pif.out_word);
	endproperty
	a_load_word: assert property (p_load_word)
		else $error("channel A word is not the delayed sample");

	property p_strobe_a;
		@(posedge clk_in) disable iff (!rst_n_in)
		s_load_a |-> s_word_a_shown;
	endproperty
	a_strobe_a: assert property (p_strobe_a)
		else $error("channel A strobe missing after a new word");

	property p_data_pair;
		@(posedge clk_in) disable iff (!rst_n_in)
		chan_a_bits_comp_out == ~chan_a_bits_true_out &&
		chan_b_bits_comp_out == ~chan_b_bits_true_out;
	endproperty
	a_data_pair: assert property (p_data_pair)
		else $error("data complement does not mirror true output");

	property p_strobe_pair;
		@(posedge clk_in) disable iff (!rst_n_in)
		ready_strobe_chan_a_comp_out != ready_strobe_chan_a_true_out &&
		ready_strobe_chan_b_comp_out != ready_strobe_chan_b_true_out;
	endproperty
	a_strobe_pair: assert property (p_strobe_pair)
		else $error("strobe complement does not mirror true output");

	property p_sync_freeze;
		@(posedge clk_in) disable iff (!rst_n_in)
		state_reg == ST_HALT |=> $stable(strobe_a_reg) &&
			$stable(strobe_b_reg);
	endproperty
	a_sync_freeze: assert property (p_sync_freeze)
		else $error("strobe toggled while sync was held");

	property p_sync_discard;
		@(posedge clk_in) disable iff (!rst_n_in)
		sync_s2_reg |-> !pif.in_valid;
	endproperty
	a_sync_discard: assert property (p_sync_discard)
		else $error("sample taken during sync entered as valid");

	property p_startup_quiet;
		@(posedge clk_in) disable iff (!rst_n_in)
		state_reg == ST_STARTUP |-> !strobe_a_reg && !strobe_b_reg &&
			word_a_reg == WORD_RESET && !pif.in_valid;
	endproperty
	a_startup_quiet: assert property (p_startup_quiet)
		else $error("output activity before startup ended");

	property p_startup_end;
		@(posedge clk_in) disable iff (!rst_n_in)
		$rose(running) |-> $past(start_cnt_reg) == STARTUP_LAST;
	endproperty
	a_startup_end: assert property (p_startup_end)
		else $error("startup interval ended at the wrong count");

	property p_sync_halts;
		@(posedge clk_in) disable iff (!rst_n_in)
		running && sync_s2_reg |=> state_reg == ST_HALT && !phase_reg;
	endproperty
	a_sync_halts: assert property (p_sync_halts)
		else $error("sync level did not halt the port");
endmodule : adc_output_port
`default_nettype wire

// ==== adc_port_pkg.sv ====
// constants shared by the converter output port and its latency pipeline
package adc_port_pkg;
	localparam int SAMPLE_W = 12;
	localparam int LATENCY_CYCLES = 40;
	localparam int CLK_PERIOD_NS = 8;
	localparam int STARTUP_MAX_NS = 600_000_000;
	localparam int STARTUP_CYCLES = STARTUP_MAX_NS / CLK_PERIOD_NS;
	localparam int STARTUP_W = 27;
	localparam logic [SAMPLE_W-1:0] WORD_RESET = 12'h000;
	localparam logic [SAMPLE_W-1:0] CODE_POS_FULL = 12'h7ff;
	localparam logic [SAMPLE_W-1:0] CODE_ZERO = 12'h000;
	localparam logic [SAMPLE_W-1:0] CODE_NEG_FULL = 12'h800;
	typedef enum logic [1:0] {ST_STARTUP, ST_RUN, ST_HALT} port_state_t;
endpackage : adc_port_pkg

// ==== sample_pipe_if.sv ====
// carrier between the output port control and its latency pipeline
`timescale 1ns/1ps
`default_nettype none
interface sample_pipe_if #(parameter int W = 12);
	logic shift;
	logic in_valid;
	logic [W-1:0] in_word;
	logic out_valid;
	logic [W-1:0] out_word;
	modport feed (output shift, output in_valid, output in_word,
		input out_valid, input out_word);
	modport pipe (input shift, input in_valid, input in_word,
		output out_valid, output out_word);
endinterface : sample_pipe_if
`default_nettype wire

// ==== sample_pipe.sv ====
// fixed-length delay line for sample words, one step per encode edge
`timescale 1ns/1ps
`default_nettype none
module sample_pipe #(
	parameter int W = 12,
	parameter int STAGES = 40
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// words in and out
	sample_pipe_if.pipe p
);
	import adc_port_pkg::*;

	logic [W:0] stage_reg [STAGES];
	logic [W:0] stage_next [STAGES];

	always_comb begin
		for (int i = 0; i < STAGES; i++) begin
			stage_next[i] = stage_reg[i];
		end
		if (p.shift) begin
			stage_next[0] = {p.in_valid, p.in_word};
			for (int i = 1; i < STAGES; i++) begin
				stage_next[i] = stage_reg[i-1];
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			for (int i = 0; i < STAGES; i++) begin
				stage_reg[i] <= '0;
			end
		end else begin
			for (int i = 0; i < STAGES; i++) begin
				stage_reg[i] <= stage_next[i];
			end
		end
	end

	assign p.out_valid = stage_reg[STAGES-1][W];
	assign p.out_word = stage_reg[STAGES-1][W-1:0];

	property p_pipe_step;
		@(posedge clk_in) disable iff (!rst_n_in)
		p.shift |=> stage_reg[0] == $past({p.in_valid, p.in_word});
	endproperty
	a_pipe_step: assert property (p_pipe_step)
		else $error("pipeline entry did not take the sample");

	property p_pipe_hold;
		@(posedge clk_in) disable iff (!rst_n_in)
		!p.shift |=> $stable(p.out_word) && $stable(p.out_valid);
	endproperty
	a_pipe_hold: assert property (p_pipe_hold)
		else $error("pipeline moved without an encode edge");
endmodule : sample_pipe
`default_nettype wire

// ==== capture_model.sv ====
// capture-side model: registers each channel word on its ready strobe
`timescale 1ns/1ps
`default_nettype none
module capture_model (
	// channel pins from the converter
	input wire logic [11:0] a_bits_in,
	input wire logic [11:0] b_bits_in,
	input wire logic strobe_a_in,
	input wire logic strobe_b_in,
	// last captured word and running count
	output logic [11:0] word_out,
	output logic chan_b_out,
	output var int count_out
);
	// small delay stands in for the receiver's setup margin
	initial begin
		count_out = 0;
		forever begin
			@(posedge strobe_a_in or posedge strobe_b_in);
			#1;
			// after a load only the loaded channel's strobe is high
			chan_b_out = strobe_b_in;
			word_out = strobe_b_in ? b_bits_in : a_bits_in;
			count_out = count_out + 1;
		end
	end
endmodule : capture_model
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the converter output port
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin \
	n_errors++; \
	$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
	end end
module testbench;
	import adc_port_pkg::*;
	typedef struct {logic [11:0] code; logic [11:0] exp;} row_t;
	row_t rows [8] = '{'{12'h7ff, 12'h7ff}, '{12'h000, 12'h000},
		'{12'h800, 12'h800}, '{12'hfff, 12'hfff}, '{12'h001, 12'h001},
		'{12'h555, 12'h555}, '{12'haaa, 12'haaa}, '{12'h123, 12'h123}};
	logic clk_in = 0, rst_n_in, enc_clk = 0, sync_pin = 0;
	logic [11:0] sample = 0, cur_exp = 0, cap_word;
	logic [11:0] a_t, a_c, b_t, b_c;
	logic sa_t, sa_c, sb_t, sb_c, cap_chan, exp_b = 0, skip_chan = 0;
	logic [1:0] held;
	logic [11:0] exp_at [int];
	int n_errors = 0, n_tests = 0, n_enc = 0, cap_cnt, n0;
	int min_k = 0, lo = 1, hi = 0, n_halt = 0;

	adc_output_port #(.STARTUP_COUNT(20)) dut (.clk_in(clk_in),
		.rst_n_in(rst_n_in), .enc_clk_in(enc_clk), .sync_pin_in(sync_pin),
		.sample_in(sample), .chan_a_bits_true_out(a_t),
		.chan_a_bits_comp_out(a_c), .ready_strobe_chan_a_true_out(sa_t),
		.ready_strobe_chan_a_comp_out(sa_c), .chan_b_bits_true_out(b_t),
		.chan_b_bits_comp_out(b_c), .ready_strobe_chan_b_true_out(sb_t),
		.ready_strobe_chan_b_comp_out(sb_c));
	capture_model far_end (.a_bits_in(a_t), .b_bits_in(b_t),
		.strobe_a_in(sa_t), .strobe_b_in(sb_t), .word_out(cap_word),
		.chan_b_out(cap_chan), .count_out(cap_cnt));

	always #4 clk_in = ~clk_in;
	// encode clock free-running, unrelated in phase to clk_in
	always #62.5 enc_clk = ~enc_clk;

	// ordinary cases: one row per encode edge, changed mid-period
	always begin
		foreach (rows[i]) begin
			@(negedge enc_clk);
			@(negedge clk_in);
			sample = rows[i].code;
			cur_exp = rows[i].exp;
		end
	end
	always @(posedge enc_clk) begin
		n_enc = n_enc + 1;
		exp_at[n_enc] = cur_exp;
	end

	task automatic check_capture();
		int k;
		k = n_enc - LATENCY_CYCLES;
		`CHK(k >= min_k, 1'b1)
		`CHK(k < lo || k > hi, 1'b1)
		`CHK(cap_word, exp_at[k])
		`CHK({a_c, b_c}, ~{a_t, b_t})
		`CHK({sa_c, sb_c}, ~{sa_t, sb_t})
		// after a halt a repeated A load shows no new strobe edge
		if (!skip_chan)
			`CHK(cap_chan, exp_b)
		skip_chan = 0;
		exp_b = ~cap_chan;
	endtask : check_capture
	always @(cap_cnt) if (cap_cnt != 0) check_capture();
	// counts halted cycles, so a caught sync pulse can be seen
	always @(negedge clk_in) if (dut.state_reg == ST_HALT) n_halt++;

	task automatic check_reset_values();
		`CHK({a_t, b_t, sa_t, sb_t}, 26'h0)
		`CHK({a_c, b_c, sa_c, sb_c}, 26'h3ffffff)
	endtask : check_reset_values

	task automatic end_of_test();
		if (n_errors == 0 && n_tests > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_of_test

	initial begin
		#100us;
		n_errors++;
		end_of_test();
	end

	initial begin
		// a real falling edge, so every async reset branch fires
		#1 rst_n_in = 0;
		// 25 cycles meet the 200 ns minimum reset width
		repeat (25) @(negedge clk_in);
		check_reset_values();
		rst_n_in = 1;
		min_k = n_enc + 1;
		repeat (20) begin
			@(negedge clk_in);
			`CHK({sa_t, sb_t}, 2'b00)
		end
		repeat (60) @(posedge enc_clk);
		// synchronous hold of the sync pin, mid encode period
		@(negedge enc_clk);
		@(negedge clk_in);
		sync_pin = 1;
		lo = n_enc + 1;
		skip_chan = 1;
		repeat (4) @(negedge clk_in);
		held = {sa_t, sb_t};
		repeat (40) begin
			@(negedge clk_in);
			`CHK({sa_t, sb_t}, held)
		end
		@(negedge enc_clk);
		@(negedge clk_in);
		hi = n_enc;
		sync_pin = 0;
		n0 = cap_cnt;
		repeat (50) @(posedge enc_clk);
		`CHK(cap_cnt > n0, 1'b1)
		// short asynchronous pulse that falls between two clk edges
		@(negedge enc_clk);
		@(posedge clk_in);
		n0 = n_halt;
		#1 sync_pin = 1;
		skip_chan = 1;
		#5 sync_pin = 0;
		repeat (8) @(negedge clk_in);
		`CHK(n_halt > n0, 1'b1)
		n0 = cap_cnt;
		repeat (50) @(posedge enc_clk);
		`CHK(cap_cnt > n0, 1'b1)
		// second reset in mid-stream clears the pipeline
		@(negedge enc_clk);
		@(negedge clk_in);
		rst_n_in = 0;
		#1 check_reset_values();
		repeat (25) @(negedge clk_in);
		rst_n_in = 1;
		min_k = n_enc + 1;
		exp_b = 0;
		skip_chan = 0;
		repeat (50) @(posedge enc_clk);
		end_of_test();
	end
endmodule : testbench
`default_nettype wire
